// ===== logic/process_alarm_pkg.sv
// Constants and types for the three-channel process alarm unit.
// Assumes one 200 MHz clock and a synchronous active-high reset.
`default_nettype none

package process_alarm_pkg;

   // ---------------------------------------------------------------
   // Widths and counts
   // ---------------------------------------------------------------
   localparam int VAL_W     = 16;
   localparam int NUM_CH    = 3;
   localparam int SMOOTH_W  = 6;   // Smoothing time in 0.1 s steps
   localparam int MARGIN_W  = 7;   // Clear margin in 0.1 % of span steps

   // ---------------------------------------------------------------
   // Time base
   // ---------------------------------------------------------------
   localparam longint CLK_HZ       = 200_000_000;
   localparam longint TICK_TIME_MS = 100;
   localparam longint TICK_CYCLES  = (CLK_HZ * TICK_TIME_MS) / 1000;

   // ---------------------------------------------------------------
   // Ranges
   // ---------------------------------------------------------------
   localparam logic [SMOOTH_W-1:0] SMOOTH_MAX     = 6'h32;  // 5.0 s
   localparam logic [SMOOTH_W-1:0] SMOOTH_DEFAULT = 6'h04;  // 0.4 s
   localparam logic [MARGIN_W-1:0] MARGIN_MIN     = 7'h01;  // 0.1 %
   localparam logic [MARGIN_W-1:0] MARGIN_MAX     = 7'h64;  // 10.0 %
   localparam logic [MARGIN_W-1:0] MARGIN_DEFAULT = 7'h0A;  // 1.0 %
   localparam int                  PERMILLE       = 1000;
   localparam int                  LIMIT_PCT      = 110;

   // ---------------------------------------------------------------
   // Register map (word addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_FULL_SCALE = 8'h00;
   localparam logic [7:0] ADDR_SETPOINT   = 8'h01;
   localparam logic [7:0] ADDR_STATUS     = 8'h02;
   localparam logic [7:0] ADDR_CH_BASE    = 8'h10;
   localparam logic [7:0] ADDR_CH_STRIDE  = 8'h04;
   localparam logic [1:0] OFS_CONFIG      = 2'h0;
   localparam logic [1:0] OFS_THRESHOLD   = 2'h1;
   localparam logic [1:0] OFS_REARM       = 2'h2;
   localparam logic [1:0] OFS_FILTERED    = 2'h3;

   localparam logic [VAL_W-1:0] FULL_SCALE_RESET = 16'h2710;

   // ---------------------------------------------------------------
   // Modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_OFF, SRC_PROCESS, SRC_BAND, SRC_DEVIATION
   } alarm_source_select_e;

   typedef enum logic [1:0] {
      KIND_HIGH, KIND_LOW, KIND_INHIBITED_LOW
   } alarm_kind_select_e;

   typedef enum logic {
      CLEAR_AUTO, CLEAR_LATCHED
   } alarm_clear_policy_e;

   typedef enum logic {
      ENERGIZED_WHEN_HEALTHY, ENERGIZED_WHEN_ALARMED
   } relay_polarity_mode_e;

   typedef struct packed {
      alarm_source_select_e  alarm_source_select;
      alarm_kind_select_e    alarm_kind_select;
      logic [SMOOTH_W-1:0]   alarm_smoothing_time;
      logic [MARGIN_W-1:0]   alarm_clear_margin;
      alarm_clear_policy_e   alarm_clear_policy;
      relay_polarity_mode_e  relay_polarity_mode;
   } alarm_cfg_s;   // 19 bits

   localparam alarm_cfg_s CFG_RESET = '{
      alarm_source_select:  SRC_PROCESS,
      alarm_kind_select:    KIND_HIGH,
      alarm_smoothing_time: SMOOTH_DEFAULT,
      alarm_clear_margin:   MARGIN_DEFAULT,
      alarm_clear_policy:   CLEAR_AUTO,
      relay_polarity_mode:  ENERGIZED_WHEN_HEALTHY
   };

   localparam logic [VAL_W-1:0] THRESHOLD_RESET = 16'h0000;

endpackage

`default_nettype wire

// ===== logic/alarm_smoother.sv
// Moving-average style smoothing of the process value for one channel.
// Assumes a 100 ms tick from the parent, same clock.
`timescale 1ns/1ps
`default_nettype none

module alarm_smoother #(
   parameter int VAL_W    = 16,
   parameter int SMOOTH_W = 6
) (
   input  wire logic                i_mclk,
   input  wire logic                i_srst,
   input  wire logic                i_tick,
   input  wire logic [SMOOTH_W-1:0] i_time,
   input  wire logic [VAL_W-1:0]    i_value,
   output logic      [VAL_W-1:0]    o_value
);

   // First-order filter: y += (x - y) / 2^k, k chosen from time setting.
   // Cheaper than a true boxcar; settles in roughly the selected time.
   logic [VAL_W+7:0] acc;
   logic [3:0]       shift;
   logic [VAL_W+7:0] x_ext;
   logic [VAL_W+7:0] step;

   always_comb begin
      shift = 4'h0;
      for (int k = 1; k < 7; k++) begin
         if (int'(i_time) >= (1 << (k - 1)))
            shift = 4'(k);
      end
   end

   assign x_ext = {i_value, 8'h00};
   assign step  = (x_ext >= acc) ? ((x_ext - acc) >> shift) : ((acc - x_ext) >> shift);

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         acc <= '0;
      end else if (i_time == '0) begin
         acc <= x_ext;
      end else if (i_tick) begin
         acc <= (x_ext >= acc) ? acc + step : acc - step;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst)
         o_value <= '0;
      else
         o_value <= acc[VAL_W+7:8];
   end

endmodule // alarm_smoother

`default_nettype wire

// ===== logic/process_alarm_unit.sv
// Three-channel process alarm unit with relay coil drives.
// Assumes a synchronous process value and a pin-level operator reset.
`timescale 1ns/1ps
`default_nettype none

module process_alarm_unit #(
   parameter int VAL_W  = process_alarm_pkg::VAL_W,
   parameter int NUM_CH = process_alarm_pkg::NUM_CH
) (
   input  wire logic              i_mclk,
   input  wire logic              i_srst,
   input  wire logic [VAL_W-1:0]  i_process_value,
   input  wire logic              i_operator_reset,
   input  wire logic [7:0]        i_addr,
   input  wire logic [31:0]       i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [31:0]       o_rdata,
   output logic      [NUM_CH-1:0] o_alarm,
   output logic      [NUM_CH-1:0] o_relay_coil
);

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   // Channel index of a per-channel address, NUM_CH when none
   function automatic int ch_of(input logic [7:0] a);
      int r;
      r = NUM_CH;
      for (int c = 0; c < NUM_CH; c++) begin
         if (a[7:2] == 6'((process_alarm_pkg::ADDR_CH_BASE
                           + 8'(c) * process_alarm_pkg::ADDR_CH_STRIDE) >> 2))
            r = c;
      end
      return r;
   endfunction

   function automatic logic [VAL_W-1:0] clamp_threshold(input logic [VAL_W-1:0] v,
                                                        input logic [VAL_W-1:0] lim);
      return (v > lim) ? lim : v;
   endfunction

   // Startup mask kind, shared by the rearm gate and the alarm gate
   function automatic logic is_inhibited(input process_alarm_pkg::alarm_cfg_s k);
      return k.alarm_kind_select == process_alarm_pkg::KIND_INHIBITED_LOW;
   endfunction

   // ---------------------------------------------------------------
   // Operator reset synchroniser and edge
   // ---------------------------------------------------------------
   logic rst_meta;
   logic rst_sync;
   logic rst_prev;
   logic operator_reset_pulse;

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
         rst_prev <= 1'b0;
      end else begin
         rst_meta <= i_operator_reset;
         rst_sync <= rst_meta;
         rst_prev <= rst_sync;
      end
   end

   // Edge, not level: a held pin clears a latched alarm only once
   assign operator_reset_pulse = rst_sync & ~rst_prev;

   // ---------------------------------------------------------------
   // Filter tick
   // ---------------------------------------------------------------
   localparam int TICK_W = $clog2(process_alarm_pkg::TICK_CYCLES);
   logic [TICK_W-1:0] tick_cnt;
   logic              tick;

   assign tick = (tick_cnt == TICK_W'(process_alarm_pkg::TICK_CYCLES - 1));

   always_ff @(posedge i_mclk) begin
      if (i_srst || tick)
         tick_cnt <= '0;
      else
         tick_cnt <= tick_cnt + 1'b1;
   end

   // ---------------------------------------------------------------
   // Global registers
   // ---------------------------------------------------------------
   logic [VAL_W-1:0] full_scale;
   // Setpoint is the centre for band and deviation channels
   logic [VAL_W-1:0] setpoint;
   logic [VAL_W-1:0] threshold_limit;
   logic [VAL_W+7:0] limit_wide;

   assign limit_wide      = (24'(full_scale) * 24'(process_alarm_pkg::LIMIT_PCT)) / 24'd100;
   assign threshold_limit = (limit_wide > 24'(16'hFFFF)) ? 16'hFFFF : limit_wide[VAL_W-1:0];

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         full_scale <= process_alarm_pkg::FULL_SCALE_RESET;
         setpoint   <= '0;
      end else if (i_wr && i_addr == process_alarm_pkg::ADDR_FULL_SCALE) begin
         full_scale <= i_wdata[VAL_W-1:0];
      end else if (i_wr && i_addr == process_alarm_pkg::ADDR_SETPOINT) begin
         setpoint <= i_wdata[VAL_W-1:0];
      end
   end

   // ---------------------------------------------------------------
   // Per-channel logic
   // ---------------------------------------------------------------
   process_alarm_pkg::alarm_cfg_s cfg       [NUM_CH];
   logic [VAL_W-1:0]              threshold [NUM_CH];
   logic [VAL_W-1:0]              filtered  [NUM_CH];
   logic [NUM_CH-1:0]             suppressed;
   logic [NUM_CH-1:0]             cond_state;
   int                            wr_ch;

   assign wr_ch = ch_of(i_addr);

   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic [VAL_W+7:0] margin_wide;
      logic [VAL_W-1:0] margin;
      logic [VAL_W:0]   value;
      logic [VAL_W:0]   thr;
      logic [VAL_W:0]   lo_edge;
      logic [VAL_W:0]   hi_edge;
      logic [VAL_W:0]   half;
      logic [VAL_W:0]   off_sp;
      logic             is_off;
      logic             trip;
      logic             release_ok;
      logic             rise_seen;
      logic             cfg_wr;
      logic             chan_wr;
      logic             thr_wr;
      logic             arm_wr;
      process_alarm_pkg::alarm_cfg_s w_cfg;

      assign chan_wr = i_wr && (wr_ch == c);
      assign cfg_wr  = chan_wr && (i_addr[1:0] == process_alarm_pkg::OFS_CONFIG);
      assign thr_wr  = chan_wr && (i_addr[1:0] == process_alarm_pkg::OFS_THRESHOLD);
      assign arm_wr  = chan_wr && (i_addr[1:0] == process_alarm_pkg::OFS_REARM) && i_wdata[0];
      assign w_cfg   = process_alarm_pkg::alarm_cfg_s'(i_wdata[18:0]);

      // ---------------------------------------------------------------
      // Channel registers
      // ---------------------------------------------------------------
      // Configuration, each channel its own copy
      always_ff @(posedge i_mclk) begin
         if (i_srst) begin
            cfg[c] <= process_alarm_pkg::CFG_RESET;
         end else if (cfg_wr) begin
            cfg[c] <= w_cfg;
            if (w_cfg.alarm_smoothing_time > process_alarm_pkg::SMOOTH_MAX)
               cfg[c].alarm_smoothing_time <= process_alarm_pkg::SMOOTH_MAX;
            if (w_cfg.alarm_clear_margin < process_alarm_pkg::MARGIN_MIN)
               cfg[c].alarm_clear_margin <= process_alarm_pkg::MARGIN_MIN;
            else if (w_cfg.alarm_clear_margin > process_alarm_pkg::MARGIN_MAX)
               cfg[c].alarm_clear_margin <= process_alarm_pkg::MARGIN_MAX;
            if (w_cfg.alarm_kind_select == 2'h3)
               cfg[c].alarm_kind_select <= process_alarm_pkg::KIND_HIGH;
         end
      end

      // Limit applies at write time; a later full-scale change does not re-clamp
      always_ff @(posedge i_mclk) begin
         if (i_srst)
            threshold[c] <= process_alarm_pkg::THRESHOLD_RESET;
         else if (thr_wr)
            threshold[c] <= clamp_threshold(i_wdata[VAL_W-1:0], threshold_limit);
      end

      alarm_smoother #(
         .VAL_W    (VAL_W),
         .SMOOTH_W (process_alarm_pkg::SMOOTH_W)
      ) u_smooth (
         .i_mclk   (i_mclk),
         .i_srst   (i_srst),
         .i_tick   (tick),
         .i_time   (cfg[c].alarm_smoothing_time),
         .i_value  (i_process_value),
         .o_value  (filtered[c])
      );

      // ---------------------------------------------------------------
      // Compare and hysteresis
      // ---------------------------------------------------------------
      // Margin in engineering units: span * permille / 1000
      assign margin_wide = (24'(full_scale) * 24'(cfg[c].alarm_clear_margin))
                           / 24'(process_alarm_pkg::PERMILLE);
      assign margin      = margin_wide[VAL_W-1:0];
      assign is_off      = (cfg[c].alarm_source_select == process_alarm_pkg::SRC_OFF);
      assign half        = {2'b00, threshold[c][VAL_W-1:1]};
      assign off_sp      = (filtered[c] >= setpoint) ? 17'(filtered[c] - setpoint)
                                                    : 17'(setpoint - filtered[c]);

      // Band and deviation compare an offset from setpoint, high style
      always_comb begin
         value = {1'b0, filtered[c]};
         thr   = {1'b0, threshold[c]};
         case (cfg[c].alarm_source_select)
            process_alarm_pkg::SRC_BAND: begin
               value = off_sp;
               thr   = half;
            end
            process_alarm_pkg::SRC_DEVIATION: begin
               value = off_sp;
               thr   = {1'b0, threshold[c]};
            end
            default: begin
               value = {1'b0, filtered[c]};
               thr   = {1'b0, threshold[c]};
            end
         endcase
         lo_edge = (thr > 17'(margin)) ? thr - 17'(margin) : '0;
         hi_edge = thr + 17'(margin);
      end

      // Offset modes always trip on the high side
      always_comb begin
         trip       = 1'b0;
         release_ok = 1'b0;
         if (cfg[c].alarm_source_select != process_alarm_pkg::SRC_PROCESS ||
             cfg[c].alarm_kind_select == process_alarm_pkg::KIND_HIGH) begin
            trip       = value > thr;
            release_ok = value < lo_edge;
         end else begin
            trip       = value < thr;
            release_ok = value > hi_edge;
         end
      end

      assign rise_seen = {1'b0, filtered[c]} > {1'b0, threshold[c]};

      // ---------------------------------------------------------------
      // Mask, alarm and coil
      // ---------------------------------------------------------------
      // Startup mask: held for inhibited low until the first rise
      always_ff @(posedge i_mclk) begin
         if (i_srst) begin
            suppressed[c] <= 1'b1;
         end else if (arm_wr && is_inhibited(cfg[c])) begin
            suppressed[c] <= 1'b1;
         end else if (rise_seen) begin
            suppressed[c] <= 1'b0;
         end
      end

      // Condition with hysteresis
      always_ff @(posedge i_mclk) begin
         if (i_srst || is_off)
            cond_state[c] <= 1'b0;
         else if (trip)
            cond_state[c] <= 1'b1;
         else if (release_ok)
            cond_state[c] <= 1'b0;
      end

      // Alarm output with clear policy; a new trip beats the reset
      always_ff @(posedge i_mclk) begin
         if (i_srst || is_off) begin
            o_alarm[c] <= 1'b0;
         end else if (is_inhibited(cfg[c]) && suppressed[c] &&
                      cfg[c].alarm_source_select == process_alarm_pkg::SRC_PROCESS) begin
            o_alarm[c] <= 1'b0;
         end else if (cond_state[c]) begin
            o_alarm[c] <= 1'b1;
         end else if (cfg[c].alarm_clear_policy == process_alarm_pkg::CLEAR_AUTO) begin
            o_alarm[c] <= 1'b0;
         end else if (operator_reset_pulse) begin
            o_alarm[c] <= 1'b0;
         end
      end

      // Coil drive follows alarm and polarity one cycle later
      always_ff @(posedge i_mclk) begin
         if (i_srst)
            o_relay_coil[c] <= 1'b0;
         else if (cfg[c].relay_polarity_mode == process_alarm_pkg::ENERGIZED_WHEN_HEALTHY)
            o_relay_coil[c] <= ~o_alarm[c];
         else
            o_relay_coil[c] <= o_alarm[c];
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   // Unmapped addresses and idle cycles read as zero
   int rd_ch;
   assign rd_ch = ch_of(i_addr);

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         o_rdata <= 32'h0000_0000;
         if (i_addr == process_alarm_pkg::ADDR_FULL_SCALE)
            o_rdata <= {16'h0000, full_scale};
         else if (i_addr == process_alarm_pkg::ADDR_SETPOINT)
            o_rdata <= {16'h0000, setpoint};
         else if (i_addr == process_alarm_pkg::ADDR_STATUS)
            o_rdata <= {20'h00000, 1'b0, suppressed, 1'b0, cond_state, 1'b0, o_alarm};
         else if (rd_ch < NUM_CH) begin
            case (i_addr[1:0])
               process_alarm_pkg::OFS_CONFIG:    o_rdata <= {13'h0000, cfg[rd_ch]};
               process_alarm_pkg::OFS_THRESHOLD: o_rdata <= {16'h0000, threshold[rd_ch]};
               process_alarm_pkg::OFS_REARM:     o_rdata <= {31'h0, suppressed[rd_ch]};
               default:                          o_rdata <= {16'h0000, filtered[rd_ch]};
            endcase
         end
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

endmodule // process_alarm_unit

`default_nettype wire

// ===== bench/process_alarm_unit_sva.sv
// Port-level assertions for the process alarm unit.
// Assumes one clock domain and the bind below the module.
`timescale 1ns/1ps
`default_nettype none

module process_alarm_unit_sva #(
   parameter int VAL_W  = 16,
   parameter int NUM_CH = 3
) (
   input wire logic              i_mclk,
   input wire logic              i_srst,
   input wire logic [VAL_W-1:0]  i_process_value,
   input wire logic              i_operator_reset,
   input wire logic [7:0]        i_addr,
   input wire logic [31:0]       i_wdata,
   input wire logic              i_wr,
   input wire logic              i_rd,
   input wire logic [31:0]       o_rdata,
   input wire logic [NUM_CH-1:0] o_alarm,
   input wire logic [NUM_CH-1:0] o_relay_coil
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);

   // ---------------------------------------------------------------
   // Sequences
   // ---------------------------------------------------------------
   sequence s_cfg_read;
      i_rd && i_addr >= 8'h10 && i_addr < 8'h1C && i_addr[1:0] == 2'h0;
   endsequence
   sequence s_after_release;
      $fell(i_srst) ##1 1'b1;
   endsequence

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   AST_RESET_IDLE: assert property (@(posedge i_mclk) disable iff (1'b0)
      i_srst |=> (o_alarm == '0 && o_relay_coil == '0 && o_rdata == 32'h0000_0000))
      else $error("outputs not idle after reset edge");
   AST_DEFAULT_FAILSAFE: assert property (s_after_release |->
      (o_relay_coil == 3'h7 && o_alarm == 3'h0))
      else $error("coils not energized after reset");
   AST_COIL_HAS_CAUSE: assert property ($changed(o_relay_coil) |->
      $past(o_alarm) != $past(o_alarm, 2) || $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3)
      || $past(i_srst) || $past(i_srst, 2))
      else $error("coil changed without alarm or config change");
   AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
      else $error("read data outside read answer");
   AST_UNMAPPED_ZERO: assert property (i_rd && i_addr == 8'hFF |=> o_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_MARGIN_RANGE: assert property (s_cfg_read |=>
      o_rdata[8:2] >= 7'h01 && o_rdata[8:2] <= 7'h64 && o_rdata[31:19] == 13'h0000)
      else $error("clear margin out of range");
   AST_SMOOTH_RANGE: assert property (s_cfg_read |=> o_rdata[14:9] <= 6'h32)
      else $error("smoothing time out of range");
   AST_STATUS_RESERVED: assert property (i_rd && i_addr == 8'h02 |=>
      o_rdata[31:11] == 21'h000000 && o_rdata[7] == 1'b0 && o_rdata[3] == 1'b0)
      else $error("status reserved bits set");
   COV_ALARM: cover property ($rose(o_alarm[0]));
endmodule // process_alarm_unit_sva

bind process_alarm_unit process_alarm_unit_sva #(.VAL_W(VAL_W), .NUM_CH(NUM_CH)) u_sva (
   .i_mclk(i_mclk), .i_srst(i_srst), .i_process_value(i_process_value),
   .i_operator_reset(i_operator_reset), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_alarm(o_alarm),
   .o_relay_coil(o_relay_coil));

`default_nettype wire

// ===== bench/process_side_model.sv
// Far side of the alarm unit: pressure sensor and relay contacts.
// Assumes the bench sets the target level on the same clock.
`timescale 1ns/1ps
`default_nettype none

module process_side_model (
   input  wire logic        i_mclk,
   input  wire logic [15:0] i_target,
   input  wire logic [2:0]  i_relay_coil,
   output logic      [15:0] o_process_value,
   output logic      [2:0]  o_contact_no
);
   // Sensor sample lands one cycle after the target moves
   always_ff @(posedge i_mclk) begin
      o_process_value <= i_target;
   end
   // Normally open contact closes while its coil is energized
   assign o_contact_no = i_relay_coil;
endmodule // process_side_model

`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the process alarm unit.
// Assumes smoothing 0 for every alarm check, full scale left at its reset value.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic        i_mclk = 1'b0;
   logic        i_srst = 1'b1;
   logic        i_operator_reset = 1'b0;
   logic [7:0]  i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0000_0000;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [15:0] target = 16'h0000;
   logic [15:0] process_value;
   logic [31:0] o_rdata;
   logic [2:0]  o_alarm;
   logic [2:0]  o_relay_coil;
   logic [2:0]  contact_no;
   int          num_errors = 0;
   int          checks = 0;
   int          cycles = 0;

   always #2.5 i_mclk = ~i_mclk;

   process_side_model u_far (.i_mclk(i_mclk), .i_target(target), .i_relay_coil(o_relay_coil),
      .o_process_value(process_value), .o_contact_no(contact_no));
   process_alarm_unit u_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_process_value(process_value),
      .i_operator_reset(i_operator_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .o_alarm(o_alarm), .o_relay_coil(o_relay_coil));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] ch(input int n, input logic [1:0] ofs);
      return 8'(8'h10 + 4 * n) | {6'h00, ofs};
   endfunction
   // Smoothing 0 so that the 100 ms time base never matters
   function automatic logic [31:0] cfg(input logic [1:0] s, input logic [1:0] k,
                                       input logic pol, input logic pl);
      return {13'h0000, s, k, 6'h00, 7'h0A, pl, pol};
   endfunction

   task automatic close_out();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk3(input string what, input logic [2:0] exp, input logic [2:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      chk32("read data", exp, o_rdata);
   endtask

   // Disable first so a stale latched state never carries over
   task automatic set_ch(input int n, input logic [31:0] c, input logic [31:0] thr);
      wr(ch(n, 2'h0), cfg(2'h0, 2'h0, c[0], 1'b0));
      wr(ch(n, 2'h1), thr);
      wr(ch(n, 2'h0), c);
   endtask

   // Sensor register plus two smoother, compare, alarm and coil stages
   task automatic level(input logic [15:0] v, input logic [2:0] al);
      @(posedge i_mclk);
      target <= v;
      repeat (8) @(posedge i_mclk);
      #1;
      chk3("alarm", al, o_alarm);
   endtask

   task automatic done(input string name);
      $display("test %s done", name);
   endtask

   always @(posedge i_mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         close_out();
      end
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge i_mclk);
      i_srst <= 1'b0;
      repeat (3) @(posedge i_mclk);
      for (int n = 0; n < 3; n++) begin
         rd(ch(n, 2'h0), 32'h0002_0828);
         rd(ch(n, 2'h1), 32'h0000_0000);
      end
      rd(8'h00, 32'h0000_2710);
      rd(8'hFF, 32'h0000_0000);
      chk3("coil", 3'h7, o_relay_coil);
      chk3("contact", 3'h7, contact_no);
      done("defaults");

      set_ch(0, cfg(2'h1, 2'h0, 1'b0, 1'b0), 32'd1000);
      set_ch(1, cfg(2'h0, 2'h0, 1'b0, 1'b0), 32'd0);
      set_ch(2, cfg(2'h1, 2'h0, 1'b1, 1'b0), 32'd2000);
      level(16'd1001, 3'h1);
      chk3("coil", 3'h2, o_relay_coil);
      level(16'd950, 3'h1);
      level(16'd899, 3'h0);
      chk3("coil", 3'h3, o_relay_coil);
      level(16'd2500, 3'h5);
      chk3("coil", 3'h6, o_relay_coil);
      rd(ch(0, 2'h3), 32'd2500);
      set_ch(2, cfg(2'h0, 2'h0, 1'b1, 1'b0), 32'd0);
      chk3("coil", 3'h2, o_relay_coil);
      done("high");

      level(16'd1500, 3'h1);
      set_ch(0, cfg(2'h1, 2'h1, 1'b0, 1'b0), 32'd1000);
      level(16'd500, 3'h1);
      level(16'd1050, 3'h1);
      level(16'd1101, 3'h0);
      done("low");

      set_ch(0, cfg(2'h1, 2'h2, 1'b0, 1'b0), 32'd1000);
      level(16'd500, 3'h1);
      wr(ch(0, 2'h2), 32'h0000_0001);
      level(16'd500, 3'h0);
      level(16'd1200, 3'h0);
      level(16'd500, 3'h1);
      wr(ch(0, 2'h2), 32'h0000_0001);
      level(16'd500, 3'h0);
      level(16'd1200, 3'h0);
      level(16'd500, 3'h1);
      done("inhibited");

      level(16'd0, 3'h1);
      set_ch(0, cfg(2'h1, 2'h0, 1'b0, 1'b1), 32'd1000);
      level(16'd1200, 3'h1);
      level(16'd0, 3'h1);
      @(posedge i_mclk);
      i_operator_reset <= 1'b1;
      repeat (4) @(posedge i_mclk);
      i_operator_reset <= 1'b0;
      level(16'd0, 3'h0);
      done("latched");

      level(16'd5000, 3'h1);
      wr(8'h01, 32'd5000);
      set_ch(0, cfg(2'h2, 2'h0, 1'b0, 1'b0), 32'd1000);
      level(16'd5400, 3'h0);
      level(16'd5600, 3'h1);
      level(16'd5000, 3'h0);
      level(16'd4400, 3'h1);
      set_ch(0, cfg(2'h3, 2'h0, 1'b0, 1'b0), 32'd1000);
      level(16'd5600, 3'h0);
      level(16'd6100, 3'h1);
      done("band");

      wr(ch(1, 2'h0), {13'h0000, 2'h1, 2'h0, 6'h3F, 7'h7F, 2'h0});
      rd(ch(1, 2'h0), 32'h0002_6590);
      wr(ch(1, 2'h0), 32'h0002_0000);
      rd(ch(1, 2'h0), 32'h0002_0004);
      wr(ch(1, 2'h1), 32'h0000_FFFF);
      rd(ch(1, 2'h1), 32'h0000_2AF8);
      done("limits");
      close_out();
   end
endmodule // testbench

`default_nettype wire
